// ### logic/sei_defs.vh
// timing and field constants for the switch event interrupt logic
`ifndef SEI_DEFS_VH
`define SEI_DEFS_VH
`define SEI_NUM_INPUTS 24
`define SEI_MODE_OFF 2'h0
`define SEI_MODE_RISE 2'h1
`define SEI_MODE_FALL 2'h2
`define SEI_MODE_BOTH 2'h3
`define SEI_SCHEME_STATIC 1'b0
`define SEI_SCHEME_DYNAMIC 1'b1
`define SEI_DEBOUNCE_RST 2'h0
`define SEI_CLK_MHZ 10
`define SEI_T_ACTIVE_US 2000
`define SEI_T_INACTIVE_US 2000
`define SEI_T_IDLE_US 2000
`define SEI_ACTIVE_CYC (`SEI_T_ACTIVE_US * `SEI_CLK_MHZ)
`define SEI_INACTIVE_CYC (`SEI_T_INACTIVE_US * `SEI_CLK_MHZ)
`define SEI_IDLE_CYC (`SEI_T_IDLE_US * `SEI_CLK_MHZ)
`endif

// ### logic/sei_sync.v
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sei_sync
#(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
)
(
  input wire i_mclk, // system clock
  input wire i_rst_n, // synchronous reset, active low
  input wire [W-1:0] i_d, // asynchronous input
  output wire [W-1:0] o_q // synchronised output
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  always @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      s1_r <= INIT;
      s2_r <= INIT;
    end
    else
    begin
      s1_r <= i_d;
      s2_r <= s1_r;
    end
  end
  assign o_q = s2_r;
endmodule

// ### logic/sei_chan.v
// per-input edge qualification and debounce
`timescale 1ns/1ps
`include "sei_defs.vh"
module sei_chan
(
  input wire i_mclk, // system clock
  input wire i_rst_n, // synchronous reset, active low
  input wire i_poll, // one polling cycle done, pulse
  input wire i_first, // first polling cycle since run start
  input wire i_run, // run-control bit
  input wire i_state, // thresholded sample
  input wire [1:0] i_mode, // edge mode, 0 disables
  input wire [1:0] i_depth, // debounce depth minus one
  output reg o_event, // input change event pulse
  output wire o_status // accepted switch status
);
  reg base_r;
  reg [1:0] cnt_r;
  always @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      base_r <= 1'b0;
      cnt_r <= 2'h0;
      o_event <= 1'b0;
    end
    else
    begin
      o_event <= 1'b0;
      if (!i_run)
        cnt_r <= 2'h0;
      else if (i_poll)
      begin
        if (i_first)
        begin
          base_r <= i_state;
          cnt_r <= 2'h0;
        end
        else if (i_state == base_r)
          cnt_r <= 2'h0;
        else if (cnt_r == i_depth)
        begin
          base_r <= i_state;
          cnt_r <= 2'h0;
          case (i_mode)
            `SEI_MODE_RISE: o_event <= i_state;
            `SEI_MODE_FALL: o_event <= ~i_state;
            `SEI_MODE_BOTH: o_event <= 1'b1;
            default: o_event <= 1'b0;
          endcase
        end
        else
          cnt_r <= cnt_r + 2'h1;
      end
    end
  end
  assign o_status = base_r;
endmodule

// ### logic/sei_top.v
// switch event interrupt logic: event flags, alert schemes and idle time
// How it works
// - alert is open-drain active low, pulled low on any monitored event.
// - scheme bit 0 picks static alert, 1 picks dynamic toggling alert.
// - static alert stays low until chip-select rise ending a flag read.
// - flags captured at first clock rise in frame; cleared when read.
// - dynamic alert toggles low then high until the flag register is read.
// - dynamic read during low releases alert and clears flags at chip-select rise.
// - dynamic read during high clears flags and blocks re-assertion for them.
// - alert scheme is static after any reset.
// - scheme may only change while run-control is zero.
// - a flag read with pending unmasked event starts an idle interval.
// - events during idle set flags now, alert deferred until idle ends.
// - second read during idle clears flags; no alert after idle.
// - per-input event enables, all off after reset.
// - rising mode: event when new sample above, old below.
// - falling mode: event when new sample below, old above.
// - both mode: event on any change of thresholded state.
// - two-bit depth needs 1 to 4 stable polls; code 11 means four.
// - first detection cycle states become baseline regardless of debounce.
// - debounce counter cleared when run-control goes to zero.
// - debounce defaults to event on every crossing.
// - sampling and alert continue while serial side is unavailable.
`timescale 1ns/1ps
`include "sei_defs.vh"
module sei_top
#(
  parameter ACTIVE_CYC = `SEI_ACTIVE_CYC,
  parameter INACTIVE_CYC = `SEI_INACTIVE_CYC,
  parameter IDLE_CYC = `SEI_IDLE_CYC
)
(
  input wire i_mclk, // 10 MHz clock
  input wire i_rst_n, // synchronous reset, active low
  input wire i_run, // run-control bit
  input wire i_scheme_wr, // pulse: write scheme bit
  input wire i_scheme, // scheme value to write
  input wire [23:0] i_state, // thresholded samples of inputs
  input wire i_poll, // polling cycle done, pulse
  input wire [47:0] i_mode, // 2-bit edge mode per input, enables
  input wire [1:0] i_debounce_depth, // debounce depth code
  input wire i_thermal_warning, // thermal warning event pulse
  input wire i_thermal_shutdown, // thermal shutdown event pulse
  input wire i_overvoltage, // overvoltage event pulse
  input wire i_cs_n, // chip select pin, active low
  input wire i_sclk, // serial clock pin
  input wire i_rd_flags, // pulse: read command to flag register decoded
  output wire o_alert_o, // alert pin output value, always 0
  output wire o_alert_oe_n, // alert output enable, low drives low
  output reg [26:0] o_flags, // flag snapshot taken at first sclk rise
  output wire [23:0] o_status, // accepted switch states
  output wire o_scheme, // current alert scheme
  output wire o_pending // flag register non-zero
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_LOW = 4'b0010;
  localparam ST_HIGH = 4'b0100;
  localparam ST_WAIT = 4'b1000;

  wire cs_n_s;
  wire sclk_s;
  wire [23:0] evt;
  reg cs_n_d_r;
  reg sclk_d_r;
  reg first_r;
  reg run_d_r;
  reg got_clk_r;
  reg read_r;
  reg scheme_r;
  reg [26:0] flags_r;
  reg [26:0] flags_nxt;
  reg [3:0] st_r;
  reg [15:0] tmr_r;
  reg idle_clr_r;
  reg [3:0] st_nxt;
  reg [15:0] tmr_nxt;
  reg idle_clr_nxt;

  sei_sync #(.W(2), .INIT(2'b10)) u_sync
  (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_d({i_cs_n, i_sclk}),
    .o_q({cs_n_s, sclk_s})
  );

  genvar g;
  generate
    for (g = 0; g < `SEI_NUM_INPUTS; g = g + 1)
    begin : g_ch
      sei_chan u_ch
      (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_poll(i_poll),
        .i_first(first_r),
        .i_run(i_run),
        .i_state(i_state[g]),
        .i_mode(i_mode[2*g+1:2*g]),
        .i_depth(i_debounce_depth),
        .o_event(evt[g]),
        .o_status(o_status[g])
      );
    end
  endgenerate

  wire cs_fall = cs_n_d_r & ~cs_n_s;
  wire cs_rise = ~cs_n_d_r & cs_n_s;
  wire sclk_rise = ~sclk_d_r & sclk_s;
  wire [26:0] new_evt = {i_overvoltage, i_thermal_shutdown, i_thermal_warning, evt};
  wire end_read = cs_rise & read_r;

  // frame tracking, run start, scheme register
  always @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      cs_n_d_r <= 1'b1;
      sclk_d_r <= 1'b0;
      first_r <= 1'b1;
      run_d_r <= 1'b0;
      got_clk_r <= 1'b0;
      read_r <= 1'b0;
      scheme_r <= `SEI_SCHEME_STATIC;
      o_flags <= 27'h000_0000;
    end
    else
    begin
      cs_n_d_r <= cs_n_s;
      sclk_d_r <= sclk_s;
      run_d_r <= i_run;
      if (i_run & ~run_d_r)
        first_r <= 1'b1;
      else if (i_poll & i_run)
        first_r <= 1'b0;
      if (i_scheme_wr & ~i_run)
        scheme_r <= i_scheme;
      if (cs_fall)
        got_clk_r <= 1'b0;
      else if (sclk_rise & ~cs_n_s & ~got_clk_r)
      begin
        got_clk_r <= 1'b1;
        o_flags <= flags_r;
      end
      if (cs_fall | cs_rise)
        read_r <= 1'b0;
      else if (i_rd_flags & ~cs_n_s)
        read_r <= 1'b1;
    end
  end

  // flag register: new events win over clear; read inside idle clears at once
  always @*
  begin
    flags_nxt = flags_r;
    if (end_read | (i_rd_flags & (st_r == ST_WAIT)))
      flags_nxt = 27'h000_0000;
    flags_nxt = flags_nxt | new_evt;
  end

  // alert sequencer
  always @*
  begin
    st_nxt = st_r;
    tmr_nxt = tmr_r;
    idle_clr_nxt = idle_clr_r;
    case (st_r)
      ST_IDLE:
      begin
        if ((flags_nxt != 27'h000_0000) && (flags_r != 27'h000_0000))
        begin
          st_nxt = ST_LOW;
          tmr_nxt = 16'h0000;
        end
      end
      ST_LOW:
      begin
        tmr_nxt = tmr_r + 16'h0001;
        if (end_read)
        begin
          st_nxt = ST_WAIT;
          tmr_nxt = 16'h0000;
          idle_clr_nxt = 1'b0;
        end
        else if (scheme_r && tmr_r == ACTIVE_CYC[15:0] - 16'h0001)
        begin
          st_nxt = ST_HIGH;
          tmr_nxt = 16'h0000;
        end
      end
      ST_HIGH:
      begin
        tmr_nxt = tmr_r + 16'h0001;
        if (end_read)
        begin
          st_nxt = ST_WAIT;
          tmr_nxt = 16'h0000;
          idle_clr_nxt = 1'b0;
        end
        else if (tmr_r == INACTIVE_CYC[15:0] - 16'h0001)
        begin
          st_nxt = ST_LOW;
          tmr_nxt = 16'h0000;
        end
      end
      ST_WAIT:
      begin
        tmr_nxt = tmr_r + 16'h0001;
        if (i_rd_flags)
          idle_clr_nxt = 1'b1;
        else if (new_evt != 27'h000_0000)
          idle_clr_nxt = 1'b0;
        if (tmr_r == IDLE_CYC[15:0] - 16'h0001)
        begin
          tmr_nxt = 16'h0000;
          // a read in the last idle cycle must still suppress the alert
          if (!idle_clr_nxt && flags_nxt != 27'h000_0000)
            st_nxt = ST_LOW;
          else
            st_nxt = ST_IDLE;
        end
      end
      default:
      begin
        st_nxt = ST_IDLE;
        tmr_nxt = 16'h0000;
      end
    endcase
  end

  always @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      flags_r <= 27'h000_0000;
      st_r <= ST_IDLE;
      tmr_r <= 16'h0000;
      idle_clr_r <= 1'b0;
    end
    else
    begin
      flags_r <= flags_nxt;
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      idle_clr_r <= idle_clr_nxt;
    end
  end

  assign o_alert_o = 1'b0;
  assign o_alert_oe_n = ~(st_r == ST_LOW);
  assign o_scheme = scheme_r;
  assign o_pending = (flags_r != 27'h000_0000);
endmodule

// ### bench/sei_top_sva.sv
// assertion checker for the switch event interrupt logic
`timescale 1ns/1ps
module sei_top_sva
(
  input wire i_mclk, // clock
  input wire i_rst_n, // reset
  input wire i_run, // run-control
  input wire i_scheme_wr, // scheme write
  input wire i_scheme, // scheme value
  input wire i_cs_n, // chip select
  input wire o_alert_o, // alert data
  input wire o_alert_oe_n, // alert enable
  input wire o_pending, // flags nonzero
  input wire o_scheme // scheme bit
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);
  property p_od; o_alert_o == 1'b0; endproperty
  a_od: assert property (p_od) else $error("alert data high");
  property p_lock; i_run |=> $stable(o_scheme); endproperty
  a_lock: assert property (p_lock) else $error("scheme moved in run");
  property p_wr; !i_run && i_scheme_wr |=> o_scheme == $past(i_scheme); endproperty
  a_wr: assert property (p_wr) else $error("scheme not written");
  property p_fell; $fell(o_alert_oe_n) |-> o_pending; endproperty
  a_fell: assert property (p_fell) else $error("alert without flag");
  property p_st; !o_scheme && $rose(o_alert_oe_n) |-> !o_pending; endproperty
  a_st: assert property (p_st) else $error("static release with flags");
  property p_dl; o_scheme && $fell(o_alert_oe_n) && i_cs_n |-> !o_alert_oe_n [*7]; endproperty
  a_dl: assert property (p_dl) else $error("dynamic low too short");
  property p_dh; o_scheme && $rose(o_alert_oe_n) && o_pending |-> o_alert_oe_n [*7]; endproperty
  a_dh: assert property (p_dh) else $error("dynamic high too short");
  property p_idle; $rose(o_alert_oe_n) && !o_pending |=> o_alert_oe_n [*6]; endproperty
  a_idle: assert property (p_idle) else $error("alert inside idle");
endmodule
bind sei_top sei_top_sva u_sva (.i_mclk, .i_rst_n, .i_run, .i_scheme_wr, .i_scheme,
  .i_cs_n, .o_alert_o, .o_alert_oe_n, .o_pending, .o_scheme);

// ### bench/sei_host.sv
// host model: chip select, serial clock and flag read command
`timescale 1ns/1ps
module sei_host
(
  input wire i_mclk, // clock
  output logic o_cs_n = 1'b1, // chip select
  output logic o_sclk = 1'b0, // serial clock, still outside frames
  output logic o_rd_flags = 1'b0 // flag read command
);
  task frame(input logic rd);
    o_cs_n <= 1'b0;
    repeat (4) @(posedge i_mclk);
    o_sclk <= 1'b1;
    repeat (4) @(posedge i_mclk);
    o_sclk <= 1'b0;
    o_rd_flags <= rd;
    @(posedge i_mclk);
    o_rd_flags <= 1'b0;
    repeat (4) @(posedge i_mclk);
    o_cs_n <= 1'b1;
    repeat (4) @(posedge i_mclk);
  endtask
  task rd_idle;
    o_rd_flags <= 1'b1;
    @(posedge i_mclk);
    o_rd_flags <= 1'b0;
  endtask
endmodule

// ### bench/sei_top_tb.sv
// testbench for the switch event interrupt logic
`timescale 1ns/1ps
module sei_top_tb;
  logic clk = 0;
  logic rst_n, run, swr, sch, poll;
  logic [2:0] evt;
  logic [23:0] st;
  logic [47:0] mode;
  logic [1:0] dep;
  wire cs_n, sclk, rd, ao, oe_n, sc, pend;
  wire [26:0] fl;
  wire [23:0] stat;
  int n_errors = 0, n_checks = 0, k;
  always #50 clk = ~clk;
  sei_host host (.i_mclk(clk), .o_cs_n(cs_n), .o_sclk(sclk), .o_rd_flags(rd));
  sei_top #(.ACTIVE_CYC(8), .INACTIVE_CYC(8), .IDLE_CYC(8)) dut (.i_mclk(clk),
    .i_rst_n(rst_n), .i_run(run), .i_scheme_wr(swr), .i_scheme(sch), .i_state(st),
    .i_poll(poll), .i_mode(mode), .i_debounce_depth(dep), .i_thermal_warning(evt[0]),
    .i_thermal_shutdown(evt[1]), .i_overvoltage(evt[2]), .i_cs_n(cs_n), .i_sclk(sclk),
    .i_rd_flags(rd), .o_alert_o(ao), .o_alert_oe_n(oe_n), .o_flags(fl),
    .o_status(stat), .o_scheme(sc), .o_pending(pend));
  task w(input int n);
    repeat (n) @(posedge clk);
  endtask
  task chk(input string nm, input logic [26:0] g, input logic [26:0] e);
    n_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error %s exp %h got %h", nm, e, g);
    end
  endtask
  task ev(input logic [2:0] m);
    evt <= m;
    w(1);
    evt <= 3'h0;
  endtask
  task pl(input logic [23:0] s);
    st <= s;
    poll <= 1'b1;
    w(1);
    poll <= 1'b0;
    w(3);
  endtask
  task sw(input logic r, input logic s);
    run <= r;
    sch <= s;
    swr <= 1'b1;
    w(1);
    swr <= 1'b0;
    w(1);
  endtask
  task t_static;
    chk("rst", {oe_n, sc, pend, stat}, 27'h400_0000);
    ev(3'h1);
    w(3);
    chk("low", oe_n, 1'b0);
    host.frame(1'b0);
    chk("snap", fl, 27'h100_0000);
    chk("kept", oe_n, 1'b0);
    host.frame(1'b1);
    chk("rel", {oe_n, pend}, 2'h2);
    ev(3'h4);
    w(1);
    chk("idle", {oe_n, pend}, 2'h3);
    w(10);
    chk("late", oe_n, 1'b0);
    host.frame(1'b1);
    ev(3'h2);
    w(1);
    host.rd_idle();
    w(2);
    chk("clr", pend, 1'b0);
    w(10);
    chk("none", oe_n, 1'b1);
  endtask
  task t_edge;
    mode <= 48'h0000_0000_0039;
    run <= 1'b1;
    w(1);
    pl(24'h00_0006);
    chk("base", pend, 1'b0);
    pl(24'h00_0009);
    host.frame(1'b1);
    chk("e1", fl, 27'h000_0007);
    pl(24'h00_0006);
    host.frame(1'b1);
    chk("e2", fl, 27'h000_0004);
    chk("stat", stat, 24'h00_0006);
    run <= 1'b0;
    dep <= 2'h3;
    w(1);
    run <= 1'b1;
    w(1);
    pl(24'h00_0000);
    repeat (3) pl(24'h00_0001);
    chk("deb3", pend, 1'b0);
    pl(24'h00_0001);
    chk("deb4", pend, 1'b1);
    host.frame(1'b1);
  endtask
  task t_dyn;
    sw(1'b0, 1'b1);
    chk("dyn", sc, 1'b1);
    sw(1'b1, 1'b0);
    chk("lock", sc, 1'b1);
    w(10);
    ev(3'h1);
    k = 0;
    repeat (32)
    begin
      w(1);
      if (oe_n === 1'b0) k++;
    end
    chk("tog", 27'(k), 27'd16);
    host.frame(1'b1);
    w(20);
    chk("dclr", {oe_n, pend}, 2'h2);
  endtask
  task test_done;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    rst_n <= 1'b0;
    run <= 1'b0;
    swr <= 1'b0;
    sch <= 1'b0;
    poll <= 1'b0;
    evt <= 3'h0;
    st <= 24'h00_0000;
    mode <= 48'h0000_0000_0000;
    dep <= 2'h0;
    w(4);
    rst_n <= 1'b1;
    w(1);
    t_static(); // static scheme suits a host that sleeps
    t_edge();
    t_dyn();
    test_done();
  end
  initial
  begin
    w(3000);
    n_errors++;
    test_done();
  end
endmodule
